// [common/srw_consts.svh]
`ifndef SRW_CONSTS_SVH
`define SRW_CONSTS_SVH

// Clock period of clock_in and the power-on one-shot time, both in nanoseconds.
`define SRW_CLK_NS 100
`define SRW_POR_NS 2500000

// Nominal RC oscillator rate in kHz and the four watchdog periods in milliseconds.
`define SRW_RC_KHZ 32
`define SRW_WD_MS_P0 5
`define SRW_WD_MS_P1 10
`define SRW_WD_MS_P2 20
`define SRW_WD_MS_P3 80

// Configuration write window after a reset release, in crystal clocks.
`define SRW_LOCK_XTAL 7'h78

// Register indices; the byte address is four times the index.
`define SRW_IDX_WAKE2 6'h0d
`define SRW_IDX_WDCFG 6'h0f
`define SRW_IDX_STATUS 6'h10

// Field positions of the second wake-select register.
`define SRW_WAKE2_SRC_LSB 2
`define SRW_WAKE2_SRC_MSB 4
`define SRW_WAKE2_LVL_BIT 6

// Field positions of the watchdog configuration register.
`define SRW_WDCFG_PER_LSB 0
`define SRW_WDCFG_PER_MSB 1
`define SRW_WDCFG_HALT_BIT 2
`define SRW_WDCFG_STOP_BIT 3

// Reset values.
`define SRW_WAKE2_SRC_RST 3'h0
`define SRW_WAKE2_LVL_RST 1'h0
`define SRW_WDCFG_PER_RST 2'h0
`define SRW_WDCFG_HALT_RST 1'h1
`define SRW_WDCFG_STOP_RST 1'h1

// Wake source codes.
`define SRW_SRC_POR 3'h0
`define SRW_SRC_P2LO_NAND 3'h1
`define SRW_SRC_P2_NAND 3'h2
`define SRW_SRC_P3_NOR 3'h3
`define SRW_SRC_P3_NAND 3'h4
`define SRW_SRC_P3P0_NOR 3'h5
`define SRW_SRC_P3P0_NAND 3'h6
`define SRW_SRC_P3P2_NAND 3'h7

// Pin membership masks over the 13 synchronised pins: [7:0] port 2, [10:8] port 3 bits 1-3,
// [11] port 0 bit 0, [12] port 0 bit 7.
`define SRW_MASK_NONE 13'h0000
`define SRW_MASK_P2LO 13'h000f
`define SRW_MASK_P2 13'h00ff
`define SRW_MASK_P3 13'h0700
`define SRW_MASK_P3P0 13'h1f00
`define SRW_MASK_P3P2 13'h0707

// Synchroniser lanes.
`define SRW_NSYNC 16
`define SRW_NPIN 13
`define SRW_SYN_BO 13
`define SRW_SYN_EXTN 14
`define SRW_SYN_RC 15
`define SRW_SYNC_RST 16'h4000

// Restart addresses and flag values driven by the watchdog instruction (Z, S, V).
`define SRW_STOP_VECTOR 16'h000c
`define SRW_RESET_VECTOR 16'h0000
`define SRW_WDT_ZSV 3'h0

// Status register bit positions.
`define SRW_ST_STOP 0
`define SRW_ST_RUN 1
`define SRW_ST_LOCK 2
`define SRW_ST_WDRST 3
`define SRW_ST_STOPREC 4

`endif

// [common/srw_pkg.sv]
`default_nettype none
package srw_pkg;
  typedef logic [31:0] srw_word_t;
  typedef logic [7:0] srw_addr_t;
  typedef logic [12:0] srw_pins_t;
  typedef enum logic [1:0] {SRW_POR_WAIT, SRW_RUN, SRW_STOP, SRW_RESTART} srw_state_e;
endpackage : srw_pkg
`default_nettype wire

// [common/srw_wd_if.sv]
`timescale 1ns/1ps
`default_nettype none
// Link between the reset controller and the watchdog counter.
interface srw_wd_if;
  logic rc_tick;
  logic active;
  logic kick;
  logic clr;
  logic [1:0] period;
  logic timeout;
  modport ctl (output rc_tick, output active, output kick, output clr, output period, input timeout);
  modport wd (input rc_tick, input active, input kick, input clr, input period, output timeout);
endinterface : srw_wd_if
`default_nettype wire

// [hdl/srw_wdog.sv]
`timescale 1ns/1ps
`default_nettype none
`include "srw_consts.svh"
module srw_wdog #(
  parameter int RC_KHZ = `SRW_RC_KHZ
) (
  input wire logic clock_in,
  input wire logic rst_in,
  srw_wd_if.wd wd
);
  import srw_pkg::*;

  // Terminal counts in RC ticks; whole ticks, so each period is at least the nominal minimum.
  localparam logic [15:0] LIM0 = 16'(`SRW_WD_MS_P0 * RC_KHZ);
  localparam logic [15:0] LIM1 = 16'(`SRW_WD_MS_P1 * RC_KHZ);
  localparam logic [15:0] LIM2 = 16'(`SRW_WD_MS_P2 * RC_KHZ);
  localparam logic [15:0] LIM3 = 16'(`SRW_WD_MS_P3 * RC_KHZ);

  logic [15:0] limit;
  logic [15:0] count_q;
  logic timeout_q;

  // Tap selection from the period field.
  always_comb begin
    case (wd.period)
      2'h0: limit = LIM0; // see RULE_10
      2'h1: limit = LIM1;
      2'h2: limit = LIM2;
      default: limit = LIM3;
    endcase
  end

  // The count advances only on RC ticks, which are sampled on clock_in, so it stalls whenever clock_in stops.
  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      count_q <= 16'h0000;
      timeout_q <= 1'b0;
    end else begin
      timeout_q <= 1'b0;
      if (wd.clr || wd.kick) begin
        count_q <= 16'h0000; // see RULE_07
      end else if (wd.active && wd.rc_tick) begin // see RULE_09
        if (count_q == limit - 16'h0001) begin
          count_q <= 16'h0000;
          timeout_q <= 1'b1; // see RULE_07
        end else begin
          count_q <= count_q + 16'h0001;
        end
      end
    end
  end

  assign wd.timeout = timeout_q;
endmodule : srw_wdog
`default_nettype wire

// [hdl/srw_top.sv]
// Behaviour
// RULE_01 - Source codes 000 to 100 pick pin gates; code 000 selects no pins here.
// RULE_02 - Codes 101 to 111 add port 0/2 pins.
// RULE_03 - Level bit sets wake polarity, default low.
// RULE_04 - Software writes zeros to reserved bits.
// RULE_05 - Either recovery register's event ends stop.
// RULE_06 - Output-mode pins drop out of the gate.
// RULE_07 - Retriggerable watchdog; instruction enables then refreshes.
// RULE_08 - Watchdog instruction updates zero, sign, overflow flags.
// RULE_09 - Watchdog counts RC oscillator ticks only.
// RULE_10 - Period field picks 5, 10, 20, 80 ms.
// RULE_11 - Halt bit keeps watchdog counting in halt.
// RULE_12 - Stop bit keeps watchdog counting in stop.
// RULE_13 - Watchdog config bits 4 to 7 unused.
// RULE_14 - Watchdog config writable 120 clocks after reset.
// RULE_15 - Watchdog config reads back as zero.
// RULE_16 - Watchdog config decoded at index 0x0f.
// RULE_17 - Brown-out holds reset, then full power-on sequence.
// RULE_18 - Strap decides watchdog running after power-on.
// RULE_19 - Power-on one-shot 2.5 ms, three triggers.
// RULE_20 - Stop ends only by reset, restart 000C.
// RULE_21 - Gate output matching level raises wake in stop.
//
// Register access over APB is this design's own decision.
`timescale 1ns/1ps
`default_nettype none
`include "srw_consts.svh"
module srw_top #(
  parameter int POR_CYCLES = (`SRW_POR_NS + `SRW_CLK_NS - 1) / `SRW_CLK_NS,
  parameter int RC_KHZ = `SRW_RC_KHZ
) (
  input wire logic clock_in,
  input wire logic rst_in,
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire srw_pkg::srw_addr_t paddr_in,
  input wire srw_pkg::srw_word_t pwdata_in,
  output var srw_pkg::srw_word_t prdata_out,
  output logic pready_out,
  output logic pslverr_out,
  input wire logic [7:0] port2_pin_in,
  input wire logic [3:1] port3_pin_in,
  input wire logic [1:0] port0_pin_in,
  input wire logic [7:0] port2_outmode_in,
  input wire logic [3:1] port3_outmode_in,
  input wire logic [1:0] port0_outmode_in,
  input wire logic brownout_in,
  input wire logic ext_reset_n_in,
  input wire logic rc_osc_in,
  input wire logic first_wake_in,
  input wire logic por_bypass_ctl_in,
  input wire logic wdt_at_por_in,
  input wire logic wdt_instr_in,
  input wire logic halt_in,
  input wire logic stop_req_in,
  output logic cpu_reset_out,
  output logic stop_out,
  output logic wake_out,
  output logic flag_we_out,
  output logic [2:0] flag_zsv_out,
  output logic [15:0] restart_addr_out
);
  import srw_pkg::*;

  localparam logic [`SRW_NSYNC-1:0] SYNC_RST = `SRW_SYNC_RST;
  localparam logic [15:0] POR_LOAD = 16'(POR_CYCLES - 1);

  srw_wd_if wd_if ();

  logic [`SRW_NSYNC-1:0] raw;
  logic [`SRW_NSYNC-1:0] s1_q;
  logic [`SRW_NSYNC-1:0] s2_q;
  logic [`SRW_NSYNC-1:0] s3_q;
  logic [`SRW_NSYNC-1:0] flt_q;
  srw_pins_t pins;
  srw_pins_t outmode;
  srw_pins_t member;
  srw_pins_t live;
  logic nor_sel;
  logic gate;
  logic pin_wake;
  logic wake_ev;
  logic bo;
  logic ext_n;
  logic rc_prev_q;
  logic rc_tick;
  srw_state_e state_q;
  srw_state_e state_d;
  logic [15:0] por_cnt_q;
  logic por_enter;
  logic rel;
  logic [6:0] win_cnt_q;
  logic win_open;
  logic [2:0] src_q;
  logic level_q;
  logic [1:0] period_q;
  logic halt_en_q;
  logic stop_en_q;
  logic running_q;
  logic kick;
  logic wd_to;
  logic wd_seen_q;
  logic stoprec_q;
  logic setup;
  logic wr;
  logic aligned;
  logic hit_wake2;
  logic hit_wdcfg;
  logic hit_stat;
  srw_word_t status;
  srw_word_t prdata_q;
  logic pready_q;
  logic pslverr_q;
  logic cpu_reset_q;
  logic stop_q;
  logic wake_q;
  logic flag_we_q;
  logic [2:0] flag_zsv_q;
  logic [15:0] restart_addr_q;

  // Every pin and the RC oscillator cross in through three flops; a change is taken once stages two and three agree.
  assign raw = {rc_osc_in, ext_reset_n_in, brownout_in, port0_pin_in, port3_pin_in, port2_pin_in};
  for (genvar i = 0; i < `SRW_NSYNC; i++) begin : g_sync
    always_ff @(posedge clock_in or posedge rst_in) begin
      if (rst_in) begin
        s1_q[i] <= SYNC_RST[i];
        s2_q[i] <= SYNC_RST[i];
        s3_q[i] <= SYNC_RST[i];
        flt_q[i] <= SYNC_RST[i];
      end else begin
        s1_q[i] <= raw[i];
        s2_q[i] <= s1_q[i];
        s3_q[i] <= s2_q[i];
        if (s2_q[i] == s3_q[i]) begin
          flt_q[i] <= s3_q[i];
        end
      end
    end
  end

  assign pins = flt_q[`SRW_NPIN-1:0];
  assign bo = flt_q[`SRW_SYN_BO];
  assign ext_n = flt_q[`SRW_SYN_EXTN];
  assign outmode = {port0_outmode_in, port3_outmode_in, port2_outmode_in};

  // Rising edge of the filtered RC oscillator gives one watchdog tick.
  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      rc_prev_q <= 1'b0;
    end else begin
      rc_prev_q <= flt_q[`SRW_SYN_RC];
    end
  end
  assign rc_tick = flt_q[`SRW_SYN_RC] & ~rc_prev_q; // see RULE_09

  // Pin group and gate kind for the programmed wake source.
  always_comb begin
    member = `SRW_MASK_NONE;
    nor_sel = 1'b0;
    case (src_q)
      `SRW_SRC_P2LO_NAND: member = `SRW_MASK_P2LO; // see RULE_01
      `SRW_SRC_P2_NAND: member = `SRW_MASK_P2; // see RULE_01
      `SRW_SRC_P3_NOR: begin
        member = `SRW_MASK_P3; // see RULE_01
        nor_sel = 1'b1;
      end
      `SRW_SRC_P3_NAND: member = `SRW_MASK_P3; // see RULE_01
      `SRW_SRC_P3P0_NOR: begin
        member = `SRW_MASK_P3P0; // see RULE_02
        nor_sel = 1'b1;
      end
      `SRW_SRC_P3P0_NAND: member = `SRW_MASK_P3P0; // see RULE_02
      `SRW_SRC_P3P2_NAND: member = `SRW_MASK_P3P2; // see RULE_02
      default: member = `SRW_MASK_NONE; // see RULE_01
    endcase
  end

  // Output-mode pins are forced neutral: one for the NAND, zero for the NOR.
  // A group with no input pin left never wakes, so an empty NOR cannot fire by accident.
  assign live = member & ~outmode; // see RULE_06
  assign gate = nor_sel ? ~|(pins & live) : ~&(pins | ~live);
  assign pin_wake = (|live) & (gate == level_q); // see RULE_03
  assign wake_ev = (state_q == SRW_STOP) & (pin_wake | first_wake_in); // see RULE_05, see RULE_21

  // Reset sequencer; brown-out wins, then watchdog timeout, then the reset pin, then wake or stop entry.
  always_comb begin
    state_d = state_q;
    if (bo) begin
      state_d = SRW_POR_WAIT; // see RULE_17
    end else begin
      case (state_q)
        SRW_POR_WAIT: begin
          if (por_cnt_q == 16'h0000) begin
            state_d = SRW_RUN;
          end
        end
        SRW_RUN: begin
          if (wd_to) begin
            state_d = SRW_POR_WAIT; // see RULE_19
          end else if (!ext_n) begin
            state_d = SRW_RESTART;
          end else if (stop_req_in) begin
            state_d = SRW_STOP;
          end
        end
        SRW_STOP: begin
          if (wd_to) begin
            state_d = SRW_POR_WAIT; // see RULE_20
          end else if (!ext_n) begin
            state_d = SRW_RESTART; // see RULE_20
          end else if (wake_ev) begin
            state_d = por_bypass_ctl_in ? SRW_POR_WAIT : SRW_RESTART; // see RULE_19, see RULE_20
          end
        end
        SRW_RESTART: begin
          if (ext_n) begin
            state_d = SRW_RUN;
          end
        end
        default: state_d = SRW_POR_WAIT;
      endcase
    end
  end

  assign por_enter = bo | ((state_d == SRW_POR_WAIT) & (state_q != SRW_POR_WAIT));
  assign rel = (state_d == SRW_RUN) & (state_q != SRW_RUN);

  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      state_q <= SRW_POR_WAIT;
    end else begin
      state_q <= state_d;
    end
  end

  // The one-shot reloads on every trigger and keeps reloading while brown-out lasts.
  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      por_cnt_q <= POR_LOAD;
    end else if (por_enter) begin
      por_cnt_q <= POR_LOAD; // see RULE_19, see RULE_17
    end else if (state_q == SRW_POR_WAIT && por_cnt_q != 16'h0000) begin
      por_cnt_q <= por_cnt_q - 16'h0001;
    end
  end

  // Configuration window opens at each reset release and closes for good after the count runs out.
  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      win_cnt_q <= 7'h00;
    end else if (rel) begin
      win_cnt_q <= `SRW_LOCK_XTAL; // see RULE_14
    end else if (state_q == SRW_RUN && win_cnt_q != 7'h00) begin
      win_cnt_q <= win_cnt_q - 7'h01;
    end
  end
  assign win_open = (state_q == SRW_RUN) & (win_cnt_q != 7'h00); // see RULE_14

  // APB decode; registers sit one per aligned word at four times their index.
  assign setup = psel_in & ~penable_in;
  assign aligned = paddr_in[1:0] == 2'h0;
  assign hit_wake2 = aligned & (paddr_in[7:2] == `SRW_IDX_WAKE2);
  assign hit_wdcfg = aligned & (paddr_in[7:2] == `SRW_IDX_WDCFG); // see RULE_16
  assign hit_stat = aligned & (paddr_in[7:2] == `SRW_IDX_STATUS);
  assign wr = psel_in & penable_in & pready_q & pwrite_in;

  always_comb begin
    status = 32'h0000_0000;
    status[`SRW_ST_STOP] = state_q == SRW_STOP;
    status[`SRW_ST_RUN] = running_q;
    status[`SRW_ST_LOCK] = ~win_open;
    status[`SRW_ST_WDRST] = wd_seen_q;
    status[`SRW_ST_STOPREC] = stoprec_q;
  end

  // Ready is raised in the cycle after setup, so every transfer has exactly one access cycle.
  // Write-only registers read as zero; only the status word returns data.
  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= 32'h0000_0000;
    end else begin
      pready_q <= setup;
      pslverr_q <= setup & ~(hit_wake2 | hit_wdcfg | hit_stat);
      prdata_q <= (setup && !pwrite_in && hit_stat) ? status : 32'h0000_0000; // see RULE_15
    end
  end

  // Second wake-select register; only source and level are kept, so reserved bits never matter.
  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      src_q <= `SRW_WAKE2_SRC_RST;
      level_q <= `SRW_WAKE2_LVL_RST;
    end else if (por_enter) begin
      src_q <= `SRW_WAKE2_SRC_RST;
      level_q <= `SRW_WAKE2_LVL_RST; // see RULE_03
    end else if (wr && hit_wake2) begin
      src_q <= pwdata_in[`SRW_WAKE2_SRC_MSB:`SRW_WAKE2_SRC_LSB]; // see RULE_04
      level_q <= pwdata_in[`SRW_WAKE2_LVL_BIT];
    end
  end

  // Watchdog configuration; a write outside the window is dropped without an error answer.
  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      period_q <= `SRW_WDCFG_PER_RST;
      halt_en_q <= `SRW_WDCFG_HALT_RST;
      stop_en_q <= `SRW_WDCFG_STOP_RST;
    end else if (por_enter) begin
      period_q <= `SRW_WDCFG_PER_RST;
      halt_en_q <= `SRW_WDCFG_HALT_RST; // see RULE_11
      stop_en_q <= `SRW_WDCFG_STOP_RST; // see RULE_12
    end else if (wr && hit_wdcfg && win_open) begin // see RULE_14
      period_q <= pwdata_in[`SRW_WDCFG_PER_MSB:`SRW_WDCFG_PER_LSB]; // see RULE_10, see RULE_13
      halt_en_q <= pwdata_in[`SRW_WDCFG_HALT_BIT];
      stop_en_q <= pwdata_in[`SRW_WDCFG_STOP_BIT];
    end
  end

  assign kick = wdt_instr_in & (state_q == SRW_RUN);

  // The strap is sampled when the power-on one-shot ends, not under reset.
  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      running_q <= 1'b0;
    end else if (por_enter) begin
      running_q <= 1'b0;
    end else if (state_q == SRW_POR_WAIT && state_d == SRW_RUN) begin
      running_q <= wdt_at_por_in; // see RULE_18
    end else if (kick) begin
      running_q <= 1'b1; // see RULE_07
    end
  end

  // Counting is gated per mode; in stop it keeps counting RC ticks, sampled on clock_in, while stop_en_q is set.
  assign wd_if.rc_tick = rc_tick;
  assign wd_if.active = running_q & (((state_q == SRW_RUN) & (~halt_in | halt_en_q)) // see RULE_11
                        | ((state_q == SRW_STOP) & stop_en_q)); // see RULE_12
  assign wd_if.kick = kick;
  assign wd_if.clr = cpu_reset_q;
  assign wd_if.period = period_q;
  assign wd_to = wd_if.timeout;

  srw_wdog #(
    .RC_KHZ(RC_KHZ)
  ) u_wdog (
    .clock_in(clock_in),
    .rst_in(rst_in),
    .wd(wd_if.wd)
  );

  // Reset cause flags for software.
  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      wd_seen_q <= 1'b0;
      stoprec_q <= 1'b0;
    end else if (bo) begin
      wd_seen_q <= 1'b0;
      stoprec_q <= 1'b0;
    end else if (state_q != state_d && state_d != SRW_RUN) begin
      wd_seen_q <= wd_to & (state_q != SRW_POR_WAIT);
      stoprec_q <= wake_ev & ~wd_to & ext_n;
    end
  end

  // Core-facing outputs, all registered from the next state.
  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      cpu_reset_q <= 1'b1;
      stop_q <= 1'b0;
      wake_q <= 1'b0;
    end else begin
      cpu_reset_q <= (state_d == SRW_POR_WAIT) || (state_d == SRW_RESTART); // see RULE_17
      stop_q <= state_d == SRW_STOP;
      wake_q <= (state_q == SRW_STOP) && (state_d != SRW_STOP); // see RULE_20
    end
  end

  // Restart address is set when run or stop is left for reset: the stop vector after a stop exit.
  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      restart_addr_q <= `SRW_RESET_VECTOR;
    end else if (state_q == SRW_STOP && state_d != SRW_STOP) begin
      restart_addr_q <= `SRW_STOP_VECTOR; // see RULE_20
    end else if (state_q == SRW_RUN && state_d != SRW_RUN && state_d != SRW_STOP) begin
      restart_addr_q <= `SRW_RESET_VECTOR;
    end
  end

  // Flag update strobe for the core, one cycle per watchdog instruction.
  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      flag_we_q <= 1'b0;
      flag_zsv_q <= 3'h0;
    end else begin
      flag_we_q <= kick; // see RULE_08
      if (kick) begin
        flag_zsv_q <= `SRW_WDT_ZSV;
      end
    end
  end

  assign prdata_out = prdata_q;
  assign pready_out = pready_q;
  assign pslverr_out = pslverr_q;
  assign cpu_reset_out = cpu_reset_q;
  assign stop_out = stop_q;
  assign wake_out = wake_q;
  assign flag_we_out = flag_we_q;
  assign flag_zsv_out = flag_zsv_q;
  assign restart_addr_out = restart_addr_q;
endmodule : srw_top
`default_nettype wire

// [verification/srw_top_props.sv]
`timescale 1ns/1ps
`default_nettype none
// Port-level checks of the stop-recovery and watchdog block.
module srw_top_props (
  input wire logic clock_in,
  input wire logic rst_in,
  input wire logic psel_in,
  input wire logic penable_in,
  input wire srw_pkg::srw_addr_t paddr_in,
  input wire logic pready_out,
  input wire logic pslverr_out,
  input wire logic brownout_in,
  input wire logic wdt_instr_in,
  input wire logic stop_req_in,
  input wire logic cpu_reset_out,
  input wire logic stop_out,
  input wire logic wake_out,
  input wire logic flag_we_out,
  input wire logic [2:0] flag_zsv_out,
  input wire logic [15:0] restart_addr_out
);
  import srw_pkg::*;
  default clocking cb @(posedge clock_in);
  endclocking
  default disable iff (rst_in);
  // A bus setup cycle, and a core that is neither held in reset nor stopped.
  sequence s_setup;
    psel_in && !penable_in;
  endsequence
  sequence s_run;
    !cpu_reset_out && !stop_out;
  endsequence
  // The slave never inserts wait states, so ready follows setup at once.
  a_ready_after_setup: assert property (s_setup |=> pready_out)
    else $error("Ready missing after setup.");
  a_ready_one_cycle: assert property (pready_out |=> !pready_out)
    else $error("Ready held too long.");
  a_error_with_ready: assert property (pslverr_out |-> pready_out)
    else $error("Error without ready.");
  a_misaligned_err: assert property (s_setup ##0 (paddr_in[1:0] != 2'h0) |=> pslverr_out)
    else $error("Misaligned access not refused.");
  a_config_mapped: assert property (s_setup ##0 (paddr_in == 8'h3c) |=> !pslverr_out)
    else $error("Watchdog config refused.");
  a_flag_update: assert property (s_run ##0 wdt_instr_in |=> flag_we_out && flag_zsv_out == 3'h0)
    else $error("Flags not written after watchdog refresh.");
  a_flag_cause: assert property (flag_we_out |-> $past(wdt_instr_in))
    else $error("Flag write without refresh.");
  a_stop_entry: assert property (s_run ##0 stop_req_in |=> stop_out)
    else $error("Stop request not honoured.");
  a_stop_restart: assert property (wake_out |-> ##[0:1] restart_addr_out == 16'h000c)
    else $error("Wrong restart address after stop.");
  a_stop_exit_wake: assert property ($fell(stop_out) |-> (wake_out || $past(wake_out)) or ##1 wake_out)
    else $error("Stop left without wake pulse.");
  // Eight cycles covers the pin synchroniser and the registered reset output.
  a_brownout_hold: assert property (brownout_in [*8] |-> cpu_reset_out)
    else $error("Reset not held in brown-out.");
endmodule : srw_top_props

bind srw_top srw_top_props srw_top_props_i (
  .clock_in, .rst_in, .psel_in, .penable_in, .paddr_in, .pready_out, .pslverr_out, .brownout_in,
  .wdt_instr_in, .stop_req_in, .cpu_reset_out, .stop_out, .wake_out, .flag_we_out, .flag_zsv_out,
  .restart_addr_out);
`default_nettype wire

// [verification/tb_stop_recovery_and_watchdog.sv]
`timescale 1ns/1ps
`default_nettype none
`include "srw_consts.svh"
module tb_stop_recovery_and_watchdog;
  import srw_pkg::*;
  localparam int POR = 20;
  localparam srw_addr_t A_WAKE = {`SRW_IDX_WAKE2, 2'h0};
  localparam srw_addr_t A_WD = {`SRW_IDX_WDCFG, 2'h0};
  localparam srw_addr_t A_ST = {`SRW_IDX_STATUS, 2'h0};
  logic clock_in = '0, rst_in = '1, psel_in = '0, penable_in = '0, pwrite_in = '0;
  srw_addr_t paddr_in = '0;
  srw_word_t pwdata_in = '0, prdata_out;
  logic pready_out, pslverr_out, cpu_reset_out, stop_out, wake_out, flag_we_out, err;
  logic [7:0] port2_pin_in = '0, port2_outmode_in = '0;
  logic [3:1] port3_pin_in = '0, port3_outmode_in = '0;
  logic [1:0] port0_pin_in = '0, port0_outmode_in = '0;
  logic brownout_in = '0, ext_reset_n_in = '1, rc_osc_in = '0, first_wake_in = '0, por_bypass_ctl_in = '0;
  logic wdt_at_por_in = '0, wdt_instr_in = '0, halt_in = '0, stop_req_in = '0;
  logic [2:0] flag_zsv_out;
  logic [15:0] restart_addr_out;
  logic [31:0] rd;
  int mismatches = 0, num_checks = 0, cyc = 0;

  // RC_KHZ of 1 turns the periods into 5, 10, 20 and 80 ticks.
  srw_top #(.POR_CYCLES(POR), .RC_KHZ(1)) srw_top_i (
    .clock_in, .rst_in, .psel_in, .penable_in, .pwrite_in, .paddr_in, .pwdata_in, .prdata_out,
    .pready_out, .pslverr_out, .port2_pin_in, .port3_pin_in, .port0_pin_in, .port2_outmode_in,
    .port3_outmode_in, .port0_outmode_in, .brownout_in, .ext_reset_n_in, .rc_osc_in, .first_wake_in,
    .por_bypass_ctl_in, .wdt_at_por_in, .wdt_instr_in, .halt_in, .stop_req_in, .cpu_reset_out,
    .stop_out, .wake_out, .flag_we_out, .flag_zsv_out, .restart_addr_out);

  // The clock.
  always #50 clock_in = ~clock_in;

  // One RC tick every eight clocks, well inside the synchroniser limit, and a guard against hangs.
  always @(posedge clock_in) begin
    cyc <= cyc + 1;
    rc_osc_in <= cyc[2];
    if (cyc == 20000) begin
      mismatches++;
      end_of_test();
    end
  end

  task end_of_test;
    if (mismatches == 0 && num_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : end_of_test

  task chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("Error at %0t ns: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task tick(input int n);
    repeat (n) @(posedge clock_in);
  endtask : tick

  // One transfer; the trailing idle cycle keeps two calls from driving psel in one time step.
  task apb(input logic w, input srw_addr_t a, input srw_word_t d);
    psel_in <= '1;
    penable_in <= '0;
    pwrite_in <= w;
    paddr_in <= a;
    pwdata_in <= d;
    @(posedge clock_in);
    penable_in <= '1;
    do @(posedge clock_in); while (pready_out !== 1'h1);
    rd = prdata_out;
    err = pslverr_out;
    psel_in <= '0;
    penable_in <= '0;
    @(posedge clock_in);
  endtask : apb

  task rdchk(input srw_addr_t a, input logic [31:0] d, input logic e);
    apb(1'h0, a, '0);
    chk(rd, d);
    chk(32'(err), 32'(e));
  endtask : rdchk

  task until_rst(input logic v, output int n);
    n = 0;
    while (cpu_reset_out !== v && n < 1000) begin
      @(posedge clock_in);
      n++;
    end
  endtask : until_rst

  task kick;
    wdt_instr_in <= '1;
    @(posedge clock_in);
    wdt_instr_in <= '0;
    @(posedge clock_in);
  endtask : kick

  function automatic logic wake_fn(input logic [2:0] c, input logic l, input logic [12:0] e, input logic [12:0] om);
    logic [12:0] m;
    case (c)
      3'h1: m = 13'h000f;
      3'h2: m = 13'h00ff;
      3'h3, 3'h4: m = 13'h0700;
      3'h5, 3'h6: m = 13'h1f00;
      3'h7: m = 13'h0707;
      default: m = 13'h0000;
    endcase
    m = m & ~om;
    if (c == 3'h3 || c == 3'h5) return m != 0 && !(|(e & m)) == l;
    return m != 0 && !(&(e | ~m)) == l;
  endfunction : wake_fn

  task t_por(input logic bo);
    int n;
    if (bo) begin
      brownout_in <= '1;
      tick(30);
      chk(32'(cpu_reset_out), 32'h1);
      brownout_in <= '0;
    end
    until_rst(1'h0, n);
    chk(32'(n >= POR && n <= POR + 10), 32'h1);
  endtask : t_por

  task t_regs;
    apb(1'h1, A_WAKE, 32'h0000_0044);
    rdchk(A_WAKE, 32'h0, 1'h0);
    rdchk(A_WD, 32'h0, 1'h0);
    rdchk(8'h20, 32'h0, 1'h1);
    rdchk(8'h3d, 32'h0, 1'h1);
  endtask : t_regs

  // Idle pins sit at the level that keeps either gate type inactive, then the case pattern lands in stop.
  task t_wake(input logic [2:0] c, input logic l, input logic [12:0] e, input logic [12:0] om);
    int k;
    apb(1'h1, A_WAKE, {25'h0, l, 1'h0, c, 2'h0});
    {port0_outmode_in, port3_outmode_in, port2_outmode_in} <= om;
    {port0_pin_in, port3_pin_in, port2_pin_in} <= {13{l}};
    tick(8);
    stop_req_in <= '1;
    @(posedge clock_in);
    stop_req_in <= '0;
    tick(2);
    chk(32'(stop_out), 32'h1);
    {port0_pin_in, port3_pin_in, port2_pin_in} <= e;
    k = 0;
    while (wake_out !== 1'h1 && k < 16) begin
      @(posedge clock_in);
      k++;
    end
    chk(32'(k < 16), 32'(wake_fn(c, l, e, om)));
    if (k == 16) begin
      first_wake_in <= '1;
      k = 0;
      while (wake_out !== 1'h1 && k < 16) begin
        @(posedge clock_in);
        k++;
      end
      first_wake_in <= '0;
      chk(32'(k < 16), 32'h1);
    end
    until_rst(1'h0, k);
    chk(32'(restart_addr_out), 32'h000c);
  endtask : t_wake

  // Refresh at half the period, so a missed refresh shows as an early timeout.
  task t_wd(input logic [7:0] cfg, input int n, input logic late, input logic hlt);
    int c;
    until_rst(1'h0, c);
    if (late) tick(130);
    apb(1'h1, A_WD, {24'h0, cfg});
    apb(1'h0, A_ST, '0);
    chk(32'(rd[2:1]), 32'({late, 1'h0}));
    kick;
    apb(1'h0, A_ST, '0);
    chk(32'(rd[1]), 32'h1);
    if (hlt) begin
      halt_in <= '1;
      tick(n * 8 + 40);
      chk(32'(cpu_reset_out), 32'h0);
      halt_in <= '0;
    end
    tick(n * 4);
    kick;
    until_rst(1'h1, c);
    chk(32'(c >= (n - 1) * 8 && c <= n * 8 + 16), 32'h1);
    until_rst(1'h0, c);
    apb(1'h0, A_ST, '0);
    chk(32'(rd[3]), 32'h1);
  endtask : t_wd

  // Main sequence.
  initial begin
    tick(3);
    rst_in <= '0;
    t_por(1'h0);
    t_regs;
    t_wake(3'h1, 1'h0, 13'h000f, 13'h0000);
    t_wake(3'h2, 1'h0, 13'h000f, 13'h0000);
    t_wake(3'h2, 1'h0, 13'h00ff, 13'h0000);
    t_wake(3'h3, 1'h0, 13'h0100, 13'h0000);
    t_wake(3'h4, 1'h1, 13'h1dff, 13'h0000);
    t_wake(3'h5, 1'h0, 13'h0800, 13'h0000);
    t_wake(3'h6, 1'h0, 13'h1f00, 13'h0000);
    t_wake(3'h7, 1'h0, 13'h0707, 13'h0000);
    t_wake(3'h7, 1'h0, 13'h0700, 13'h0000);
    t_wake(3'h0, 1'h0, 13'h1fff, 13'h0000);
    t_wake(3'h1, 1'h0, 13'h000e, 13'h0001);
    t_wake(3'h3, 1'h0, 13'h0100, 13'h0700);
    t_wake(3'h3, 1'h1, 13'h0000, 13'h0000);
    t_wd(8'h0c, 5, 1'h0, 1'h0);
    t_wd(8'h0d, 10, 1'h0, 1'h0);
    t_wd(8'h0e, 20, 1'h0, 1'h0);
    t_wd(8'h0f, 80, 1'h0, 1'h0);
    t_wd(8'h08, 5, 1'h0, 1'h1);
    t_wd(8'h0f, 5, 1'h1, 1'h0);
    wdt_at_por_in <= '1;
    t_por(1'h1);
    apb(1'h0, A_ST, '0);
    chk(32'(rd[1]), 32'h1);
    end_of_test();
  end
endmodule : tb_stop_recovery_and_watchdog
`default_nettype wire
